/* File: smmde_exit.sv */
// Management-mode VM exit sequencer with its APB register file.
// Assumes core events arrive as one-cycle pulses synchronous to pclk and that
// the core holds the I/O snapshot inputs stable from the event until the exit starts, at least a cycle later.
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module smmde_exit
  import smmde_pkg::*;
#(
  parameter logic [15:0] REASON_IO_SMI = 16'h0001,
  parameter logic [15:0] REASON_OTHER_SMI = 16'h0002,
  parameter logic [15:0] REASON_CALL = 16'h0003
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclken,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [SMMDE_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mgmt_interrupt,
  input wire logic monitor_call_instr,
  input wire logic virt_off_instr,
  input wire logic resume_from_mgmt_instr,
  input wire logic return_entry,
  input wire logic deactivate_treatment_ctl,
  input wire logic nmi_unblock,
  input wire logic current_ptr_load,
  input wire logic [63:0] current_ptr_value,
  input wire logic in_hw_virtualization,
  input wire logic in_root_op,
  input wire logic monitor_trap_pending,
  input wire logic io_retired,
  input wire logic [2:0] io_width_bytes,
  input wire logic io_dir_in,
  input wire logic io_string,
  input wire logic io_rep,
  input wire logic io_immediate,
  input wire logic [15:0] io_port,
  input wire logic io_segment_usable,
  input wire logic in_64bit_mode,
  input wire logic [63:0] io_linear_addr,
  input wire logic [63:0] io_count_snapshot,
  input wire logic [63:0] io_source_index_snapshot,
  input wire logic [63:0] io_dest_index_snapshot,
  input wire logic [63:0] io_instr_pointer_snapshot,
  input wire logic [63:0] root_region_pointer,
  input wire logic [31:0] management_base_register,
  input wire logic save_timer_ctl,
  input wire logic activate_timer_ctl,
  input wire logic [31:0] preemption_timer,
  output logic management_mode,
  output logic treatment_active,
  output logic mgmt_interrupt_blocked,
  output logic nmi_blocked,
  output logic [63:0] current_struct_ptr,
  output logic exit_done,
  output logic virt_off_fail,
  output logic default_smi_delivery,
  output logic flush_req,
  output logic [15:0] flush_vm_identifier
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    smmde_state_type st;
    logic monitor_valid;
    logic keep_block;
    logic active;
    logic mgmt_mode;
    logic smi_pending;
    logic smi_blocked;
    logic nmi_blk;
    logic from_root;
    logic timer_defined;
    logic [31:0] reason;
    logic [63:0] qual;
    logic [63:0] linear;
    logic [63:0] cnt;
    logic [63:0] src;
    logic [63:0] dst;
    logic [63:0] ip;
    logic [31:0] mbase;
    logic [31:0] timer;
    logic [63:0] exec_ptr;
    logic [63:0] cur_ptr;
    logic [63:0] xfer_ptr;
    logic rd_valid;
    logic [31:0] rdata;
    logic done;
    logic off_fail;
    logic dflt;
    logic flush;
  } smmde_regs_type;

  smmde_regs_type s;
  smmde_regs_type n;

  logic apb_hold;
  logic apb_fire;
  logic mapped;
  logic [31:0] rmux;
  logic [2:0] size_code;
  logic call_take;
  logic smi_ready;

  // ****************************************************************
  // Register read decode
  // ****************************************************************
  always_comb begin
    mapped = 1'b1;
    rmux = SMMDE_ZERO32;
    case (paddr)
      SMMDE_MONCTL: begin
        rmux[SMMDE_MONCTL_VALID] = s.monitor_valid;
        rmux[SMMDE_MONCTL_KEEP_BLOCK] = s.keep_block;
      end
      SMMDE_STATUS: begin
        rmux[SMMDE_ST_ACTIVE] = s.active;
        rmux[SMMDE_ST_MGMT] = s.mgmt_mode;
        rmux[SMMDE_ST_SMI_BLK] = s.smi_blocked;
        rmux[SMMDE_ST_NMI_BLK] = s.nmi_blk;
        rmux[SMMDE_ST_BUSY] = (s.st != SMMDE_IDLE);
        rmux[SMMDE_ST_PENDING] = s.smi_pending;
      end
      SMMDE_REASON: rmux = s.reason;
      SMMDE_QUAL_LO: rmux = s.qual[31:0];
      SMMDE_QUAL_HI: rmux = s.qual[63:32];
      SMMDE_LIN_LO: rmux = s.linear[31:0];
      SMMDE_LIN_HI: rmux = s.linear[63:32];
      SMMDE_CNT_LO: rmux = s.cnt[31:0];
      SMMDE_CNT_HI: rmux = s.cnt[63:32];
      SMMDE_SRC_LO: rmux = s.src[31:0];
      SMMDE_SRC_HI: rmux = s.src[63:32];
      SMMDE_DST_LO: rmux = s.dst[31:0];
      SMMDE_DST_HI: rmux = s.dst[63:32];
      SMMDE_IP_LO: rmux = s.ip[31:0];
      SMMDE_IP_HI: rmux = s.ip[63:32];
      SMMDE_MBASE: rmux = s.mbase;
      SMMDE_TIMER: rmux = s.timer;
      SMMDE_EXEC_LO: rmux = s.exec_ptr[31:0];
      SMMDE_EXEC_HI: rmux = s.exec_ptr[63:32];
      SMMDE_CUR_LO: rmux = s.cur_ptr[31:0];
      SMMDE_CUR_HI: rmux = s.cur_ptr[63:32];
      SMMDE_XFER_LO: rmux = s.xfer_ptr[31:0];
      SMMDE_XFER_HI: rmux = s.xfer_ptr[63:32];
      default: mapped = 1'b0;
    endcase
  end

  // ****************************************************************
  // Access size encoding
  // ****************************************************************
  always_comb begin
    case (io_width_bytes)
      3'h2: size_code = SMMDE_SIZE_2B;
      3'h4: size_code = SMMDE_SIZE_4B;
      default: size_code = SMMDE_SIZE_1B;
    endcase
  end

  // Read data is captured in the setup cycle so prdata comes from a flop and
  // a zero-wait answer is still possible; a frozen clock enable stalls pready.
  assign apb_hold = psel && !(penable && s.rd_valid);
  assign apb_fire = psel && penable && s.rd_valid && pclken;

  // A root-mode call needs only the valid bit; the treatment may still be off.
  assign call_take = monitor_call_instr && in_hw_virtualization && in_root_op && !s.mgmt_mode
    && s.monitor_valid && (s.st == SMMDE_IDLE);
  assign smi_ready = s.smi_pending && !s.smi_blocked && !s.mgmt_mode && (s.st == SMMDE_IDLE);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    n = s;
    n.done = 1'b0;
    n.off_fail = 1'b0;
    n.dflt = 1'b0;
    n.flush = 1'b0;

    n.rd_valid = apb_hold;
    if (apb_hold) begin
      n.rdata = rmux;
    end
    if (apb_fire && pwrite && mapped) begin
      case (paddr)
        SMMDE_MONCTL: begin
          n.monitor_valid = pwdata[SMMDE_MONCTL_VALID];
          n.keep_block = pwdata[SMMDE_MONCTL_KEEP_BLOCK];
        end
        SMMDE_XFER_LO: n.xfer_ptr[31:0] = pwdata;
        SMMDE_XFER_HI: n.xfer_ptr[63:32] = pwdata;
        default: n.xfer_ptr = s.xfer_ptr;
      endcase
    end

    if (nmi_unblock) begin
      n.nmi_blk = 1'b0;
    end
    if (current_ptr_load && (s.st == SMMDE_IDLE)) begin
      n.cur_ptr = current_ptr_value;
    end

    // Virt-off is refused whenever the treatment is active, in or out of management mode.
    if (virt_off_instr && s.active) begin
      n.off_fail = 1'b1;
    end else if (virt_off_instr && !s.mgmt_mode && (s.st == SMMDE_IDLE) && !s.keep_block) begin
      n.smi_blocked = 1'b0;
    end

    // Returning entry leaves management mode and is one unblock path, beside resume and virt-off.
    if (return_entry && s.mgmt_mode && s.active && (s.st == SMMDE_IDLE)) begin
      n.mgmt_mode = 1'b0;
      if (deactivate_treatment_ctl) begin
        // A deactivating entry leaves interrupts blocked; a later virt-off may release them.
        n.active = 1'b0;
      end else begin
        n.smi_blocked = 1'b0;
      end
    end
    if (resume_from_mgmt_instr && s.mgmt_mode && !s.active && (s.st == SMMDE_IDLE)) begin
      n.mgmt_mode = 1'b0;
      n.smi_blocked = 1'b0;
    end

    case (s.st)
      SMMDE_IDLE: begin
        if (call_take || (smi_ready && s.active)) begin
          n.mgmt_mode = 1'b1;
          n.from_root = in_root_op;
          n.st = SMMDE_EXEC_PTR;
          n.reason = SMMDE_ZERO32;
          n.reason[SMMDE_REASON_ROOT] = in_root_op;
          n.reason[SMMDE_REASON_MTF] = !in_root_op && monitor_trap_pending;
          n.timer_defined = !in_root_op && activate_timer_ctl;
          if (call_take) begin
            n.active = 1'b1;
            n.reason[15:0] = REASON_CALL;
          end else begin
            n.smi_pending = 1'b0;
            n.reason[15:0] = io_retired ? REASON_IO_SMI : REASON_OTHER_SMI;
            if (io_retired) begin
              n.qual = {SMMDE_ZERO32, io_port, 9'h000, io_immediate, io_rep, io_string, io_dir_in,
                size_code};
              n.cnt = io_count_snapshot;
              n.src = io_source_index_snapshot;
              n.dst = io_dest_index_snapshot;
              n.ip = io_instr_pointer_snapshot;
              if (io_string && io_segment_usable) begin
                n.linear = in_64bit_mode ? io_linear_addr : {SMMDE_ZERO32, io_linear_addr[31:0]};
              end
            end
          end
        end else if (smi_ready) begin
          // Default treatment: ordinary delivery saves to management memory.
          n.smi_pending = 1'b0;
          n.mgmt_mode = 1'b1;
          n.smi_blocked = 1'b1;
          n.nmi_blk = 1'b1;
          n.dflt = 1'b1;
          n.flush = 1'b1;
        end
      end
      SMMDE_EXEC_PTR: begin
        n.exec_ptr = s.from_root ? root_region_pointer : s.cur_ptr;
        n.st = SMMDE_CUR_PTR;
      end
      SMMDE_CUR_PTR: begin
        n.cur_ptr = s.xfer_ptr;
        n.st = SMMDE_SAVE;
      end
      SMMDE_SAVE: begin
        n.mbase = management_base_register;
        if (save_timer_ctl) begin
          // The undefined case reads back as zero.
          n.timer = s.timer_defined ? preemption_timer : SMMDE_ZERO32;
        end
        n.smi_blocked = 1'b1;
        n.nmi_blk = 1'b1;
        n.flush = 1'b1;
        n.done = 1'b1;
        n.st = SMMDE_IDLE;
      end
      default: n.st = SMMDE_IDLE;
    endcase

    // An arrival in the cycle the pending flag is consumed is kept.
    if (mgmt_interrupt) begin
      n.smi_pending = 1'b1;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else if (pclken) begin
      s <= n;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata = s.rdata;
  assign pready = psel && penable && s.rd_valid && pclken;
  assign pslverr = pready && !mapped;
  assign management_mode = s.mgmt_mode;
  assign treatment_active = s.active;
  assign mgmt_interrupt_blocked = s.smi_blocked;
  assign nmi_blocked = s.nmi_blk;
  assign current_struct_ptr = s.cur_ptr;
  assign exit_done = s.done;
  assign virt_off_fail = s.off_fail;
  assign default_smi_delivery = s.dflt;
  assign flush_req = s.flush;
  assign flush_vm_identifier = SMMDE_FLUSH_VM_IDENTIFIER;

endmodule : smmde_exit

/* File: smmde_exit_sva.sv */
// Checker for the management-mode VM exit block.
// Assumes it is bound to smmde_exit and sees only that module's ports.
`timescale 1ns/1ps
module smmde_exit_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic virt_off_instr,
  input wire logic resume_from_mgmt_instr,
  input wire logic return_entry,
  input wire logic management_mode,
  input wire logic treatment_active,
  input wire logic mgmt_interrupt_blocked,
  input wire logic nmi_blocked,
  input wire logic exit_done,
  input wire logic virt_off_fail,
  input wire logic default_smi_delivery,
  input wire logic flush_req,
  input wire logic [15:0] flush_vm_identifier
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  exit_blocks_a: assert property (exit_done |-> mgmt_interrupt_blocked && nmi_blocked)
    else $error("exit left an interrupt unblocked");
  flush_id_a: assert property (flush_vm_identifier == 16'h0000)
    else $error("flush names a nonzero identifier");
  exit_flush_a: assert property (exit_done |-> flush_req)
    else $error("exit without flush");
  off_fail_a: assert property (virt_off_instr && treatment_active |=> virt_off_fail)
    else $error("virt off did not fail");
  fail_cause_a: assert property (virt_off_fail |-> $past(virt_off_instr) && $past(treatment_active))
    else $error("spurious virt off failure");
  exit_len_a: assert property ($rose(management_mode) && !default_smi_delivery |-> !exit_done [*3] ##1 exit_done)
    else $error("exit length wrong");
  exit_mode_a: assert property (exit_done |-> treatment_active && $past(management_mode, 3))
    else $error("exit without active treatment");
  default_path_a: assert property (default_smi_delivery |-> !treatment_active && !exit_done)
    else $error("default delivery under dual treatment");
  smi_hold_a: assert property ($fell(mgmt_interrupt_blocked) |->
    $past(return_entry) || $past(virt_off_instr) || $past(resume_from_mgmt_instr))
    else $error("interrupt block released without cause");
endmodule : smmde_exit_sva

bind smmde_exit smmde_exit_sva u_sva (.*);

/* File: smmde_exit_test.sv */
// Self-checking bench for the management-mode VM exit block.
// Assumes the package and design are compiled first; the bench drives every port.
`timescale 1ns/1ps
module smmde_exit_test;
  import smmde_pkg::*;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [6:0] ev = 0;
  logic deact = 0;
  logic root = 0;
  logic monitor_trap = 0;
  logic ioret = 0;
  logic [2:0] iow = 0;
  logic [3:0] iof = 0;
  logic [15:0] port = 0;
  logic seg = 0;
  logic [63:0] lin = 0;
  logic [63:0] snap = 64'h0000_0001_0000_0040;
  logic [63:0] cptr = 0;
  logic [63:0] rootp = 64'h0000_0000_0055_A000;
  logic [31:0] mbase = 32'h000A_0000;
  logic [31:0] tmr = 32'h0000_1111;
  logic mm, ta, sb, nb, done, vfail, dsd;
  logic [63:0] csp;
  logic [31:0] rdv;
  logic err;
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  wire [1:0] flags = {dsd, done};

  smmde_exit uut (.pclk(pclk), .presetn(presetn), .pclken(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mgmt_interrupt(ev[0]), .monitor_call_instr(ev[1]), .virt_off_instr(ev[2]),
    .resume_from_mgmt_instr(ev[3]), .return_entry(ev[4]), .deactivate_treatment_ctl(deact),
    .nmi_unblock(ev[5]), .current_ptr_load(ev[6]), .current_ptr_value(cptr), .in_hw_virtualization(1'b1),
    .in_root_op(root), .monitor_trap_pending(monitor_trap), .io_retired(ioret), .io_width_bytes(iow),
    .io_dir_in(iof[3]), .io_string(iof[2]), .io_rep(iof[1]), .io_immediate(iof[0]), .io_port(port),
    .io_segment_usable(seg), .in_64bit_mode(1'b0), .io_linear_addr(lin), .io_count_snapshot(snap),
    .io_source_index_snapshot(snap + 64'h1), .io_dest_index_snapshot(snap + 64'h2),
    .io_instr_pointer_snapshot(snap + 64'h3), .root_region_pointer(rootp), .management_base_register(mbase),
    .save_timer_ctl(1'b1), .activate_timer_ctl(1'b1), .preemption_timer(tmr), .management_mode(mm),
    .treatment_active(ta), .mgmt_interrupt_blocked(sb), .nmi_blocked(nb), .current_struct_ptr(csp),
    .exit_done(done), .virt_off_fail(vfail), .default_smi_delivery(dsd), .flush_req(), .flush_vm_identifier());

  // ****************************************
  // Bus and event tasks
  // ****************************************
  always #50 pclk = ~pclk;

  task automatic close_out;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      close_out;
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    chk(pready, 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask : rd

  task pulse(input int i);
    @(posedge pclk);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev[i] <= 1'b0;
  endtask : pulse

  task automatic waitf(input int k);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (flags[k] !== 1'b1 && n < 12);
    chk(flags[k], 1'b1);
  endtask : waitf

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(SMMDE_STATUS, 32'h0);
    root <= 1'b1;
    pulse(1);
    repeat (6) @(posedge pclk);
    chk(mm, 1'b0);
    apb(1'b1, SMMDE_XFER_LO, 32'h0000_2000);
    apb(1'b1, SMMDE_XFER_HI, 32'h0000_0001);
    apb(1'b1, SMMDE_MONCTL, 32'h1);
    pulse(1);
    waitf(0);
    chk(csp, 64'h1_0000_2000);
    rd(SMMDE_REASON, 32'h2000_0003);
    rd(SMMDE_EXEC_LO, rootp[31:0]);
    rd(SMMDE_MBASE, mbase);
    rd(SMMDE_STATUS, 32'h0F);
    rd(SMMDE_TIMER, 32'h0);
    pulse(2);
    @(posedge pclk);
    chk(vfail, 1'b1);
    pulse(4);
    root <= 1'b0;
    monitor_trap <= 1'b1;
    ioret <= 1'b1;
    iof <= 4'hF;
    port <= 16'hBEEF;
    seg <= 1'b1;
    lin <= 64'h1234_5678_9ABC_DEF0;
    for (int i = 0; i < 3; i++) begin
      iow <= 3'(1 << i);
      cptr <= 64'hCAFE_0000_0000_1000 + 64'(i);
      pulse(6);
      pulse(0);
      waitf(0);
      rd(SMMDE_QUAL_LO, {16'hBEEF, 9'h0, 4'hF, 3'(i == 2 ? 3 : i)});
      rd(SMMDE_QUAL_HI, 32'h0);
      rd(SMMDE_REASON, 32'h1000_0001);
      rd(SMMDE_EXEC_LO, cptr[31:0]);
      rd(SMMDE_LIN_LO, 32'h9ABC_DEF0);
      rd(SMMDE_LIN_HI, 32'h0);
      rd(SMMDE_CNT_HI, 32'h1);
      rd(SMMDE_IP_LO, 32'h43);
      rd(SMMDE_TIMER, tmr);
      pulse(4);
    end
    pulse(5);
    @(posedge pclk);
    chk(nb, 1'b0);
    pulse(0);
    waitf(0);
    chk(nb, 1'b1);
    deact <= 1'b1;
    pulse(4);
    deact <= 1'b0;
    @(posedge pclk);
    chk(ta, 1'b0);
    apb(1'b1, SMMDE_MONCTL, 32'h5);
    pulse(2);
    @(posedge pclk);
    chk(sb, 1'b1);
    apb(1'b1, SMMDE_MONCTL, 32'h0);
    pulse(2);
    @(posedge pclk);
    chk(vfail, 1'b0);
    chk(sb, 1'b0);
    pulse(0);
    waitf(1);
    apb(1'b0, 8'hFC, 32'h0);
    chk({err, rdv}, {1'b1, 32'h0});
    apb(1'b1, SMMDE_STATUS, 32'hFFFF_FFFF);
    rd(SMMDE_STATUS, 32'h0E);
    close_out;
  end
endmodule : smmde_exit_test

/* File: smmde_pkg.sv */
// Constants, register map and state types for the management-mode VM exit block.
// Assumes a 32-bit APB master and a core that presents its events as one-cycle pulses.
// Summary of operation
// - Management interrupt under dual treatment or root-mode monitor call outside management mode starts an exit.
// - Root-mode monitor call exits only while the monitor control valid bit is set.
// - With control bit 2 set, virt-off never unblocks management interrupts.
// - Root-mode monitor call exits even under default treatment and activates dual treatment.
// - Virt-off fails while dual-monitor treatment is active.
// - An exiting management interrupt goes straight to the exit, no memory state save.
// - Executive pointer gets current pointer from non-root, root-region pointer from root.
// - Then current pointer loads from transfer pointer; exit data goes there.
// - Exit reason bits 15:0 hold I/O interrupt, other interrupt or monitor call.
// - Exit reason bit 29 set when the exit came from root operation.
// - Bit 28 set only for non-root exit with monitor trap pending; 27:16, 31:30 clear.
// - Qualification bits 2:0 give size: 0 one byte, 1 two, 3 four bytes.
// - Qualification bits 3..6: direction in, string, repeat, immediate operand.
// - Qualification bits 31:16 carry the I/O port number.
// - Qualification bits 15:7 and 63:32 are written as zero.
// - String I/O with usable segment saves start linear address; upper half clear outside 64-bit.
// - I/O exits save count, source, destination and instruction pointer from before the instruction.
// - Every exit saves the management base register.
// - Save-timer control saves the preemption timer; undefined from root or inactive timer.
// - Every exit blocks NMIs and management interrupts; each has its own unblock path.
// - Every exit invalidates translations of VM identifier 0000H for all contexts and tags.
package smmde_pkg;

  localparam int unsigned SMMDE_AW = 8;

  // Register byte offsets.
  localparam logic [7:0] SMMDE_MONCTL = 8'h00;
  localparam logic [7:0] SMMDE_STATUS = 8'h04;
  localparam logic [7:0] SMMDE_REASON = 8'h08;
  localparam logic [7:0] SMMDE_QUAL_LO = 8'h0C;
  localparam logic [7:0] SMMDE_QUAL_HI = 8'h10;
  localparam logic [7:0] SMMDE_LIN_LO = 8'h14;
  localparam logic [7:0] SMMDE_LIN_HI = 8'h18;
  localparam logic [7:0] SMMDE_CNT_LO = 8'h1C;
  localparam logic [7:0] SMMDE_CNT_HI = 8'h20;
  localparam logic [7:0] SMMDE_SRC_LO = 8'h24;
  localparam logic [7:0] SMMDE_SRC_HI = 8'h28;
  localparam logic [7:0] SMMDE_DST_LO = 8'h2C;
  localparam logic [7:0] SMMDE_DST_HI = 8'h30;
  localparam logic [7:0] SMMDE_IP_LO = 8'h34;
  localparam logic [7:0] SMMDE_IP_HI = 8'h38;
  localparam logic [7:0] SMMDE_MBASE = 8'h3C;
  localparam logic [7:0] SMMDE_TIMER = 8'h40;
  localparam logic [7:0] SMMDE_EXEC_LO = 8'h44;
  localparam logic [7:0] SMMDE_EXEC_HI = 8'h48;
  localparam logic [7:0] SMMDE_CUR_LO = 8'h4C;
  localparam logic [7:0] SMMDE_CUR_HI = 8'h50;
  localparam logic [7:0] SMMDE_XFER_LO = 8'h54;
  localparam logic [7:0] SMMDE_XFER_HI = 8'h58;

  // Field positions.
  localparam int unsigned SMMDE_MONCTL_VALID = 0;
  localparam int unsigned SMMDE_MONCTL_KEEP_BLOCK = 2;
  localparam int unsigned SMMDE_REASON_MTF = 28;
  localparam int unsigned SMMDE_REASON_ROOT = 29;
  localparam int unsigned SMMDE_ST_ACTIVE = 0;
  localparam int unsigned SMMDE_ST_MGMT = 1;
  localparam int unsigned SMMDE_ST_SMI_BLK = 2;
  localparam int unsigned SMMDE_ST_NMI_BLK = 3;
  localparam int unsigned SMMDE_ST_BUSY = 4;
  localparam int unsigned SMMDE_ST_PENDING = 5;

  // Access size codes of the I/O qualification.
  localparam logic [2:0] SMMDE_SIZE_1B = 3'h0;
  localparam logic [2:0] SMMDE_SIZE_2B = 3'h1;
  localparam logic [2:0] SMMDE_SIZE_4B = 3'h3;

  localparam logic [15:0] SMMDE_FLUSH_VM_IDENTIFIER = 16'h0000;
  localparam logic [31:0] SMMDE_ZERO32 = 32'h0000_0000;

  typedef enum logic [1:0] {
    SMMDE_IDLE,
    SMMDE_EXEC_PTR,
    SMMDE_CUR_PTR,
    SMMDE_SAVE
  } smmde_state_type;

endpackage : smmde_pkg
